/* File: logic/mlm_regs.vh */
/*
 * register offsets, field positions, reset values and frame constants of the
 * link monitor and user access front end.
 * assumes a 32-bit apb with byte addresses on paddr[7:0].
 */
`ifndef MLM_REGS_VH
`define MLM_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MLM_OFF_CTRL      8'h00
`define MLM_OFF_LMSEL0    8'h04
`define MLM_OFF_UACC1     8'h08
`define MLM_OFF_ISTS      8'h0C
`define MLM_OFF_IMASK     8'h10
`define MLM_OFF_IMCLR     8'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define MLM_CTRL_EN       0
`define MLM_CTRL_BUSY     8
`define MLM_CTRL_LINK     9
`define MLM_LM_LSEL       7
`define MLM_LM_LIEN       6
`define MLM_LM_MON        4:0
`define MLM_UA_GO         31
`define MLM_UA_WR         30
`define MLM_UA_ACK        29
`define MLM_UA_REG        25:21
`define MLM_UA_PHY        20:16
`define MLM_UA_DATA       15:0
`define MLM_IRQ_LINK      0
`define MLM_IRQ_DONE      1

// ----------------------------------------
// reset values
// ----------------------------------------
`define MLM_RST_5         5'h00
`define MLM_RST_16        16'h0000
`define MLM_RST_IRQ       2'h0

// ----------------------------------------
// frame constants
// ----------------------------------------
`define MLM_PREAMBLE      32'hFFFFFFFF
`define MLM_START         2'h1
`define MLM_OP_RD         2'h2
`define MLM_OP_WR         2'h1
`define MLM_TA_WR         2'h2
`define MLM_BIT_TA0       6'h2E
`define MLM_BIT_TA1       6'h2F
`define MLM_BIT_DATA      6'h30
`define MLM_BIT_LAST      6'h3F
`define MLM_STATUS_REG    5'h01
`define MLM_LINK_BIT      2

`endif

/* File: logic/mlm_top.v */
/*
 * apb register front end of an mdio management controller: link monitor
 * select, user access channel 1, interrupt status and mask, and the mdio
 * frame shifter that serves both.
 * assumes mdc arrives from outside the pclk domain and is sampled by pclk;
 * the mdio wire is resolved outside from mdio_out and mdio_oe_n.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mlm_regs.vh"

module mlm_top (
	// apb slave
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// interrupt
	output reg         irq,
	// mdio link
	input  wire        mdc,
	input  wire        mdio_in,
	output reg         mdio_out,
	output reg         mdio_oe_n
);

	// ----------------------------------------
	// state codes
	// ----------------------------------------
	localparam [1:0] ST_IDLE   = 2'h0;
	localparam [1:0] ST_SHIFT  = 2'h1;
	localparam [1:0] ST_FINISH = 2'h2;

	// ----------------------------------------
	// storage
	// ----------------------------------------
	reg        en_ff,    nxt_en;
	reg        lsel_ff,  nxt_lsel;
	reg        lien_ff,  nxt_lien;
	reg [4:0]  mon_ff,   nxt_mon;
	reg        go_ff,    nxt_go;
	reg        wr_ff,    nxt_wr;
	reg        ack_ff,   nxt_ack;
	reg [4:0]  rega_ff,  nxt_rega;
	reg [4:0]  phya_ff,  nxt_phya;
	reg [15:0] data_ff,  nxt_data;
	reg [1:0]  ists_ff,  nxt_ists;
	reg [1:0]  imask_ff, nxt_imask;
	reg        link_ff,  nxt_link;
	reg [1:0]  state_ff, nxt_state;
	reg [5:0]  cnt_ff,   nxt_cnt;
	reg [63:0] sr_ff,    nxt_sr;
	reg [15:0] rx_ff,    nxt_rx;
	reg        rack_ff,  nxt_rack;
	reg        user_ff,  nxt_user;
	reg        fwr_ff,   nxt_fwr;
	reg        nxt_out;
	reg        nxt_oe_n;
	reg        nxt_ready;
	reg [31:0] nxt_rdata;
	reg        nxt_err;
	reg        ev_link;
	reg        ev_done;
	reg [5:0]  nb;
	reg        mdc_s1_ff, mdc_s2_ff, mdc_s3_ff, mdc_lvl_ff;
	reg        din_s1_ff, din_s2_ff, din_s3_ff, din_lvl_ff;
	wire       wr_acc;
	wire       rd_setup;
	wire       mdc_rise;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [63:0] build_frame;
		input       is_wr;
		input [4:0] phy;
		input [4:0] rnum;
		input [15:0] wdat;
		begin
			build_frame = {`MLM_PREAMBLE, `MLM_START, (is_wr ? `MLM_OP_WR : `MLM_OP_RD), phy, rnum,
				`MLM_TA_WR, (is_wr ? wdat : 16'hFFFF)};
		end
	endfunction

	function addr_hit;
		input [7:0] a;
		begin
			addr_hit = (a == `MLM_OFF_CTRL) || (a == `MLM_OFF_LMSEL0) || (a == `MLM_OFF_UACC1) ||
				(a == `MLM_OFF_ISTS) || (a == `MLM_OFF_IMASK) || (a == `MLM_OFF_IMCLR);
		end
	endfunction

	// ----------------------------------------
	// apb handshake
	// ----------------------------------------
	assign wr_acc   = psel & penable & pready & pwrite;
	assign rd_setup = psel & penable & ~pready;

	always @* begin
		nxt_ready = rd_setup;
		nxt_err   = rd_setup & ~addr_hit(paddr);
		nxt_rdata = 32'h00000000;
		if (rd_setup && !pwrite) begin
			case (paddr)
				`MLM_OFF_CTRL: begin
					nxt_rdata[`MLM_CTRL_EN]   = en_ff;
					nxt_rdata[`MLM_CTRL_BUSY] = (state_ff != ST_IDLE);
					nxt_rdata[`MLM_CTRL_LINK] = link_ff;
				end
				`MLM_OFF_LMSEL0: begin
					nxt_rdata[`MLM_LM_LSEL] = lsel_ff;
					nxt_rdata[`MLM_LM_LIEN] = lien_ff;
					nxt_rdata[`MLM_LM_MON]  = mon_ff;
				end
				`MLM_OFF_UACC1: begin
					nxt_rdata[`MLM_UA_GO]   = go_ff;
					nxt_rdata[`MLM_UA_WR]   = wr_ff;
					nxt_rdata[`MLM_UA_ACK]  = ack_ff;
					nxt_rdata[`MLM_UA_REG]  = rega_ff;
					nxt_rdata[`MLM_UA_PHY]  = phya_ff;
					nxt_rdata[`MLM_UA_DATA] = data_ff;
				end
				`MLM_OFF_ISTS:  nxt_rdata[1:0] = ists_ff;
				`MLM_OFF_IMASK: nxt_rdata[1:0] = imask_ff;
				`MLM_OFF_IMCLR: nxt_rdata[1:0] = imask_ff;
				default:        nxt_rdata = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	assign mdc_rise = (mdc_s2_ff == mdc_s3_ff) && mdc_s3_ff && !mdc_lvl_ff;

	// ----------------------------------------
	// register writes and frame engine
	// ----------------------------------------
	always @* begin
		nxt_en    = en_ff;
		nxt_lsel  = lsel_ff;
		nxt_lien  = lien_ff;
		nxt_mon   = mon_ff;
		nxt_go    = go_ff;
		nxt_wr    = wr_ff;
		nxt_ack   = ack_ff;
		nxt_rega  = rega_ff;
		nxt_phya  = phya_ff;
		nxt_data  = data_ff;
		nxt_imask = imask_ff;
		nxt_link  = link_ff;
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_sr    = sr_ff;
		nxt_rx    = rx_ff;
		nxt_rack  = rack_ff;
		nxt_user  = user_ff;
		nxt_fwr   = fwr_ff;
		nxt_out   = mdio_out;
		nxt_oe_n  = mdio_oe_n;
		ev_link   = 1'b0;
		ev_done   = 1'b0;
		nb        = cnt_ff + 6'h01;
		if (wr_acc) begin
			case (paddr)
				`MLM_OFF_CTRL: nxt_en = pwdata[`MLM_CTRL_EN];
				`MLM_OFF_LMSEL0: begin
					nxt_lsel = pwdata[`MLM_LM_LSEL];
					nxt_lien = pwdata[`MLM_LM_LIEN];
					nxt_mon  = pwdata[`MLM_LM_MON];
				end
				`MLM_OFF_UACC1: begin
					if (!go_ff) begin
						nxt_wr   = pwdata[`MLM_UA_WR];
						nxt_ack  = pwdata[`MLM_UA_ACK];
						nxt_rega = pwdata[`MLM_UA_REG];
						nxt_phya = pwdata[`MLM_UA_PHY];
						nxt_data = pwdata[`MLM_UA_DATA];
						if (pwdata[`MLM_UA_GO] && en_ff)
							nxt_go = 1'b1;
					end
				end
				`MLM_OFF_IMASK: nxt_imask = pwdata[1:0];
				`MLM_OFF_IMCLR: nxt_imask = imask_ff & ~pwdata[1:0];
				default: nxt_imask = nxt_imask;
			endcase
		end
		case (state_ff)
			ST_IDLE: begin
				if (en_ff) begin
					nxt_state = ST_SHIFT;
					nxt_cnt   = 6'h00;
					nxt_rx    = `MLM_RST_16;
					nxt_rack  = 1'b0;
					nxt_oe_n  = 1'b0;
					nxt_user  = go_ff;
					if (go_ff) begin
						nxt_fwr = wr_ff;
						nxt_sr  = build_frame(wr_ff, phya_ff, rega_ff, data_ff);
					end else begin
						nxt_fwr = 1'b0;
						nxt_sr  = build_frame(1'b0, mon_ff, `MLM_STATUS_REG, `MLM_RST_16);
					end
					nxt_out = nxt_sr[63];
				end
			end
			ST_SHIFT: begin
				if (mdc_rise) begin
					if (cnt_ff == `MLM_BIT_TA1)
						nxt_rack = ~din_lvl_ff;
					if (cnt_ff >= `MLM_BIT_DATA)
						nxt_rx = {rx_ff[14:0], din_lvl_ff};
					if (cnt_ff == `MLM_BIT_LAST) begin
						nxt_state = ST_FINISH;
						nxt_out   = 1'b1;
						nxt_oe_n  = 1'b1;
					end else begin
						nxt_cnt  = nb;
						nxt_sr   = {sr_ff[62:0], 1'b1};
						nxt_out  = sr_ff[62];
						nxt_oe_n = !fwr_ff && (nb >= `MLM_BIT_TA0);
					end
				end
			end
			ST_FINISH: begin
				nxt_state = ST_IDLE;
				if (user_ff) begin
					nxt_go  = 1'b0;
					ev_done = 1'b1;
					if (!fwr_ff) begin
						nxt_ack  = rack_ff;
						nxt_data = rx_ff;
					end
				end else if (rack_ff) begin
					nxt_link = rx_ff[`MLM_LINK_BIT];
					if (rx_ff[`MLM_LINK_BIT] != link_ff)
						ev_link = lien_ff;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
		nxt_ists = ists_ff;
		if (wr_acc && paddr == `MLM_OFF_ISTS)
			nxt_ists = ists_ff & ~pwdata[1:0];
		nxt_ists[`MLM_IRQ_LINK] = nxt_ists[`MLM_IRQ_LINK] | ev_link;
		nxt_ists[`MLM_IRQ_DONE] = nxt_ists[`MLM_IRQ_DONE] | ev_done;
	end

	// ----------------------------------------
	// flip-flops
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata     <= 32'h00000000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			irq        <= 1'b0;
			mdio_out   <= 1'b1;
			mdio_oe_n  <= 1'b1;
			en_ff      <= 1'b0;
			lsel_ff    <= 1'b0;
			lien_ff    <= 1'b0;
			mon_ff     <= `MLM_RST_5;
			go_ff      <= 1'b0;
			wr_ff      <= 1'b0;
			ack_ff     <= 1'b0;
			rega_ff    <= `MLM_RST_5;
			phya_ff    <= `MLM_RST_5;
			data_ff    <= `MLM_RST_16;
			ists_ff    <= `MLM_RST_IRQ;
			imask_ff   <= `MLM_RST_IRQ;
			link_ff    <= 1'b0;
			state_ff   <= ST_IDLE;
			cnt_ff     <= 6'h00;
			sr_ff      <= 64'hFFFFFFFFFFFFFFFF;
			rx_ff      <= `MLM_RST_16;
			rack_ff    <= 1'b0;
			user_ff    <= 1'b0;
			fwr_ff     <= 1'b0;
			mdc_s1_ff  <= 1'b0;
			mdc_s2_ff  <= 1'b0;
			mdc_s3_ff  <= 1'b0;
			mdc_lvl_ff <= 1'b0;
			din_s1_ff  <= 1'b1;
			din_s2_ff  <= 1'b1;
			din_s3_ff  <= 1'b1;
			din_lvl_ff <= 1'b1;
		end else begin
			prdata     <= nxt_rdata;
			pready     <= nxt_ready;
			pslverr    <= nxt_err;
			irq        <= |(nxt_ists & nxt_imask);
			mdio_out   <= nxt_out;
			mdio_oe_n  <= nxt_oe_n;
			en_ff      <= nxt_en;
			lsel_ff    <= nxt_lsel;
			lien_ff    <= nxt_lien;
			mon_ff     <= nxt_mon;
			go_ff      <= nxt_go;
			wr_ff      <= nxt_wr;
			ack_ff     <= nxt_ack;
			rega_ff    <= nxt_rega;
			phya_ff    <= nxt_phya;
			data_ff    <= nxt_data;
			ists_ff    <= nxt_ists;
			imask_ff   <= nxt_imask;
			link_ff    <= nxt_link;
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			sr_ff      <= nxt_sr;
			rx_ff      <= nxt_rx;
			rack_ff    <= nxt_rack;
			user_ff    <= nxt_user;
			fwr_ff     <= nxt_fwr;
			mdc_s1_ff  <= mdc;
			mdc_s2_ff  <= mdc_s1_ff;
			mdc_s3_ff  <= mdc_s2_ff;
			if (mdc_s2_ff == mdc_s3_ff)
				mdc_lvl_ff <= mdc_s3_ff;
			din_s1_ff  <= mdio_in;
			din_s2_ff  <= din_s1_ff;
			din_s3_ff  <= din_s2_ff;
			if (din_s2_ff == din_s3_ff)
				din_lvl_ff <= din_s3_ff;
		end
	end

endmodule // mlm_top

`default_nettype wire

/* File: logic/README_unused.v */
`timescale 1ns/1ps

/* File: verif/mlm_checker.sv */
/* pin-level assertions for mlm_top.
   assumes a bind into mlm_top and one pclk domain. */
`timescale 1ns/1ps
`default_nettype none
module mlm_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq,
	input wire logic        mdc,
	input wire logic        mdio_in,
	input wire logic        mdio_out,
	input wire logic        mdio_oe_n
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_one_wait: assert property ($rose(penable) |=> pready) else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
	a_err_unmapped: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h14))
		else $error("pslverr wrong");
	a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
	a_rdata_quiet: assert property (!pready |-> prdata == 32'h0) else $error("prdata not quiet");
	a_start_one: assert property ($fell(mdio_oe_n) |-> mdio_out) else $error("frame start low");
	a_frame_hold: assert property ($fell(mdio_oe_n) |=> !mdio_oe_n [*8]) else $error("frame cut");
endmodule // mlm_checker
bind mlm_top mlm_checker chk (.*);
`default_nettype wire

/* File: verif/mlm_phy_model.sv */
/* behavioural phy on the mdio link, with mdc source.
   assumes the bench resolves the wire with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module mlm_phy_model #(
	parameter logic [4:0] PHY_ADDR = 5'h03
) (
	output var logic mdc,
	input  wire logic mdio,
	output var logic drv,
	output var logic dout
);
	logic [15:0] mem [0:31];
	logic [12:0] hdr;
	logic [14:0] dsh;
	logic [5:0]  cnt;
	logic [5:0]  ones;
	logic        infr;
	initial begin
		mdc = 1'b0;
		drv = 1'b0;
		dout = 1'b1;
		infr = 1'b0;
		ones = 6'h00;
		cnt = 6'h00;
		hdr = 13'h0000;
		foreach (mem[i]) mem[i] = 16'h0000;
		mem[1] = 16'h0004;
		#7;
		forever #160 mdc = ~mdc;
	end
	// sample on mdc rise: preamble, header, write data
	always @(posedge mdc) begin
		if (!infr) begin
			if (mdio) ones <= (ones == 6'h20) ? ones : ones + 6'h01;
			else if (ones == 6'h20) begin
				infr <= 1'b1;
				cnt <= 6'h20;
			end else ones <= 6'h00;
		end else begin
			cnt <= cnt + 6'h01;
			if (cnt < 6'h2D) hdr <= {hdr[11:0], mdio};
			if (cnt >= 6'h2F) dsh <= {dsh[13:0], mdio};
			if (cnt == 6'h3E) begin
				infr <= 1'b0;
				ones <= 6'h00;
				if (hdr[11:10] == 2'h1 && hdr[9:5] == PHY_ADDR) mem[hdr[4:0]] <= {dsh, mdio};
			end
		end
	end
	// drive ack then data on mdc fall of an addressed read
	always @(negedge mdc) begin
		drv <= infr && hdr[11:10] == 2'h2 && hdr[9:5] == PHY_ADDR && cnt >= 6'h2E;
		if (cnt == 6'h2E)
			dout <= 1'b0;
		else if (cnt > 6'h2E && cnt < 6'h3F)
			dout <= mem[hdr[4:0]][4'(6'h3E - cnt)];
		else
			dout <= 1'b1;
	end
endmodule // mlm_phy_model
`default_nettype wire

/* File: verif/testbench.sv */
/* self-checking bench for mlm_top over apb.
   assumes mlm_phy_model on the mdio wire, pulled up. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] q;
	logic        serr;
	int          err_count = 0;
	int          compares = 0;
	wire  [31:0] prdata;
	wire         pready, pslverr, irq, mdc, mdio_out, mdio_oe_n, phy_oe, phy_do, mdio_w;
	assign mdio_w = !mdio_oe_n ? mdio_out : (phy_oe ? phy_do : 1'b1);
	always #20 pclk = ~pclk;
	mlm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.mdc(mdc), .mdio_in(mdio_w), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n));
	mlm_phy_model phy (.mdc(mdc), .mdio(mdio_w), .drv(phy_oe), .dout(phy_do));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, q & m);
	endtask
	task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
		do begin
			xfer(1'b0, a, 32'h0);
		end while (q[b] !== v);
	endtask
	task automatic chk_irq(input logic e);
		@(negedge pclk);
		chk("irq", {31'h0, e}, {31'h0, irq});
		@(posedge pclk);
	endtask
	task automatic give_verdict;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#(40 * 40000);
		err_count++;
		give_verdict;
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(8'h04, 32'hFFFFFFFF, 32'h0, "lmsel reset");
		rdc(8'h08, 32'hFFFFFFFF, 32'h0, "uacc reset");
		rdc(8'h00, 32'hFFFFFFFF, 32'h0, "ctrl reset");
		xfer(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h1, {31'h0, serr});
		xfer(1'b1, 8'h08, 32'hC0A3A5C3);
		rdc(8'h08, 32'hFFFFFFFF, 32'h40A3A5C3, "go while off");
		$display("test reset done");
		xfer(1'b1, 8'h04, 32'h00000043);
		rdc(8'h04, 32'hFFFFFFFF, 32'h43, "lmsel rw");
		xfer(1'b1, 8'h10, 32'h3);
		xfer(1'b1, 8'h00, 32'h1);
		xfer(1'b1, 8'h08, 32'hC0A3A5C3);
		rdc(8'h08, 32'h80000000, 32'h80000000, "go queued");
		xfer(1'b1, 8'h08, 32'h0);
		rdc(8'h08, 32'hFFFFFFFF, 32'hC0A3A5C3, "write blocked");
		wait_bit(8'h08, 31, 1'b0);
		chk("write done", 32'h40A3A5C3, q);
		chk("phy reg", 32'hA5C3, {16'h0, phy.mem[5]});
		rdc(8'h0C, 32'h2, 32'h2, "done event");
		chk_irq(1'b1);
		xfer(1'b1, 8'h08, 32'h80A30000);
		wait_bit(8'h08, 31, 1'b0);
		chk("read acked", 32'h20A3A5C3, q);
		xfer(1'b1, 8'h08, 32'h80A70000);
		wait_bit(8'h08, 31, 1'b0);
		chk("read unacked", 32'h00A7FFFF, q);
		$display("test user access done");
		wait_bit(8'h00, 9, 1'b1);
		chk("link up", 32'h201, q & 32'h201);
		rdc(8'h0C, 32'h1, 32'h1, "link event");
		xfer(1'b1, 8'h14, 32'h2);
		rdc(8'h10, 32'hFFFFFFFF, 32'h1, "mask clear");
		xfer(1'b1, 8'h0C, 32'h3);
		chk_irq(1'b0);
		xfer(1'b1, 8'h08, 32'hC0A31234);
		wait_bit(8'h08, 31, 1'b0);
		rdc(8'h0C, 32'h2, 32'h2, "done masked");
		chk_irq(1'b0);
		chk("phy reg 2", 32'h1234, {16'h0, phy.mem[5]});
		xfer(1'b1, 8'h04, 32'h00000003);
		xfer(1'b1, 8'h0C, 32'h3);
		xfer(1'b1, 8'h08, 32'hC0230000);
		wait_bit(8'h08, 31, 1'b0);
		chk("phy link reg", 32'h0, {16'h0, phy.mem[1]});
		wait_bit(8'h00, 9, 1'b0);
		rdc(8'h0C, 32'h1, 32'h0, "link event off");
		$display("test link and irq done");
		give_verdict;
	end
endmodule // testbench
`default_nettype wire
